// ### verilog/opl_pkg.sv
// package for the set/clear output latch: register addresses, widths, reset value
// assumes a 4-bit register address bus with write strobes from the host side
package opl_pkg;
    localparam int unsigned   OPL_ADDR_W    = 4;
    localparam int unsigned   OPL_DATA_W    = 8;
    localparam logic [3:0]    OPL_SET_ADDR  = 4'hE;
    localparam logic [3:0]    OPL_CLR_ADDR  = 4'hF;
    localparam logic [7:0]    OPL_LATCH_RST = 8'h00;
endpackage

// ### verilog/opl_bit_cell.sv
// one latch bit with set and clear strobes and an inverted pin drive
// assumes set and clear are never both high in one cycle (different addresses)
`timescale 1ns/1ps
module opl_bit_cell
    import opl_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic clk_en_i,
    // strobes
    input  wire logic set_i,
    input  wire logic clr_i,
    // outputs
    output logic      bit_o,
    output logic      pin_o
);
    typedef struct packed {
        logic latch;
    } opl_cell_state_t;

    opl_cell_state_t s_q;
    opl_cell_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (set_i) begin
            s_d.latch = 1'b1;
        end else if (clr_i) begin
            s_d.latch = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_q.latch <= RST_VAL;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign bit_o = s_q.latch;
    // pin taken straight from the flop so the pin is glitch free
    assign pin_o = ~s_q.latch;
endmodule // opl_bit_cell

// ### verilog/opl_output_port_set_clear_latch.sv
// eight-bit output latch changed only through set and clear strobe registers
// assumes a synchronous host write port: address, data, one-cycle write strobe
// assumes any alternate pin functions are selected outside this block
`timescale 1ns/1ps
module opl_output_port_set_clear_latch
    import opl_pkg::*;
#(
    parameter int unsigned WIDTH = OPL_DATA_W
)
(
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  clk_en_i,
    // host register write port
    input  wire logic [OPL_ADDR_W-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]      wr_data_i,
    input  wire logic                  wr_en_i,
    // latch view and pins
    output logic      [WIDTH-1:0]      output_latch_o,
    output logic      [WIDTH-1:0]      general_out_pin_o
);
    // the strobes act bit by bit on one byte, so a wider port has no meaning
    if (WIDTH < 1 || WIDTH > OPL_DATA_W) begin : g_bad_width
        $error("output latch width must be from 1 to 8 bits");
    end
    // one write must never both set and clear, so the strobes need their own addresses
    if (OPL_SET_ADDR == OPL_CLR_ADDR) begin : g_same_addr
        $error("set and clear strobes share one address");
    end
    if ($bits(OPL_SET_ADDR) != OPL_ADDR_W) begin : g_addr_width
        $error("strobe addresses do not match the address bus width");
    end
    if ($bits(OPL_LATCH_RST) != OPL_DATA_W) begin : g_rst_width
        $error("latch reset value does not match the data width");
    end

    function automatic logic addr_hit(input logic [OPL_ADDR_W-1:0] a, input logic [OPL_ADDR_W-1:0] r);
        return a == r;
    endfunction

    // next latch value for one write; clear is applied last but the two never meet
    function automatic logic [WIDTH-1:0] next_latch(
        input logic [WIDTH-1:0] cur,
        input logic [WIDTH-1:0] set_bits,
        input logic [WIDTH-1:0] clr_bits
    );
        return (cur | set_bits) & ~clr_bits;
    endfunction

    localparam logic [WIDTH-1:0] LATCH_RST = OPL_LATCH_RST[WIDTH-1:0];

    logic             set_hit;
    logic             clr_hit;
    logic             strobe_any;
    logic [WIDTH-1:0] set_vec;
    logic [WIDTH-1:0] clr_vec;

    // any other address, and any read, leaves the latch alone
    assign set_hit = wr_en_i && addr_hit(wr_addr_i, OPL_SET_ADDR);
    assign clr_hit = wr_en_i && addr_hit(wr_addr_i, OPL_CLR_ADDR);
    assign strobe_any = set_hit || clr_hit;
    assign set_vec = set_hit ? wr_data_i : '0;
    assign clr_vec = clr_hit ? wr_data_i : '0;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            opl_bit_cell #(
                .RST_VAL    (LATCH_RST[gi])
            ) u_cell (
                .core_clk_i (core_clk_i),
                .rst_i      (rst_i),
                .clk_en_i   (clk_en_i),
                .set_i      (set_vec[gi]),
                .clr_i      (clr_vec[gi]),
                .bit_o      (output_latch_o[gi]),
                .pin_o      (general_out_pin_o[gi])
            );
        end
    endgenerate

    // reset in the same cycle wins over any strobe, so every write step excludes it
    sequence s_set_write;
        !rst_i && clk_en_i && set_hit;
    endsequence

    sequence s_clr_write;
        !rst_i && clk_en_i && clr_hit;
    endsequence

    sequence s_no_strobe;
        !rst_i && !(clk_en_i && strobe_any);
    endsequence

    sequence s_frozen;
        !rst_i && !clk_en_i;
    endsequence

    // adjacent writes: the second strobe must act on the first one's result
    sequence s_set_then_clr;
        s_set_write ##1 s_clr_write;
    endsequence

    sequence s_clr_then_set;
        s_clr_write ##1 s_set_write;
    endsequence

    sequence s_set_then_set;
        s_set_write ##1 s_set_write;
    endsequence

    sequence s_clr_then_clr;
        s_clr_write ##1 s_clr_write;
    endsequence

    a_set_ones: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_set_write |=> ((output_latch_o & $past(wr_data_i)) == $past(wr_data_i))
        && ((output_latch_o & ~$past(wr_data_i)) == ($past(output_latch_o) & ~$past(wr_data_i))))
        else $error("set strobe did not set exactly the written ones");

    a_clr_ones: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_clr_write |=> ((output_latch_o & $past(wr_data_i)) == '0)
        && ((output_latch_o & ~$past(wr_data_i)) == ($past(output_latch_o) & ~$past(wr_data_i))))
        else $error("clear strobe did not clear exactly the written ones");

    a_pin_invert: assert property (@(posedge core_clk_i) disable iff (rst_i)
        general_out_pin_o == ~output_latch_o)
        else $error("pins are not the inverse of the latch");

    a_no_other_chg: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_no_strobe |=> $stable(output_latch_o))
        else $error("latch changed without a strobe write");

    a_freeze_en: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_frozen ##1 !clk_en_i |-> $stable(output_latch_o))
        else $error("latch changed while clock enable low");

    a_reset_clear: assert property (@(posedge core_clk_i)
        rst_i |=> output_latch_o == LATCH_RST
        && general_out_pin_o == ~LATCH_RST)
        else $error("reset did not clear latch");

    a_next_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !rst_i && clk_en_i
        |=> output_latch_o == next_latch($past(output_latch_o), $past(set_vec), $past(clr_vec)))
        else $error("latch did not take the value the strobes ask for");

    a_set_pins_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_set_write |=> (general_out_pin_o & $past(wr_data_i)) == '0)
        else $error("set strobe left a pin high");

    a_clr_pins_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_clr_write |=> (general_out_pin_o & $past(wr_data_i)) == $past(wr_data_i))
        else $error("clear strobe left a pin low");

    a_set_then_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_set_then_clr
        |=> output_latch_o == next_latch($past(output_latch_o, 2), $past(wr_data_i, 2), $past(wr_data_i)))
        else $error("clear right after set did not act on the set result");

    a_clr_then_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_clr_then_set
        |=> output_latch_o == (($past(output_latch_o, 2) & ~$past(wr_data_i, 2)) | $past(wr_data_i)))
        else $error("set right after clear did not act on the clear result");

    a_set_twice: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_set_then_set
        |=> output_latch_o == ($past(output_latch_o, 2) | $past(wr_data_i, 2) | $past(wr_data_i)))
        else $error("two adjacent set writes gave the wrong latch");

    a_clr_twice: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_clr_then_clr
        |=> output_latch_o == ($past(output_latch_o, 2) & ~$past(wr_data_i, 2) & ~$past(wr_data_i)))
        else $error("two adjacent clear writes gave the wrong latch");

    a_pins_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_no_strobe |=> $stable(general_out_pin_o))
        else $error("pins changed without a strobe write");

    a_frozen_pins: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_frozen |=> $stable(general_out_pin_o))
        else $error("pins changed while clock enable low");

    // per-bit checks report the failing bit through their generate scope
    for (genvar gc = 0; gc < WIDTH; gc++) begin : g_bit_chk
        a_bit_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
            !rst_i && clk_en_i && set_vec[gc] |=> output_latch_o[gc])
            else $error("a set strobe bit did not set its latch bit");

        a_bit_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
            !rst_i && clk_en_i && clr_vec[gc] |=> !output_latch_o[gc])
            else $error("a clear strobe bit did not clear its latch bit");

        a_bit_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
            !rst_i && !(clk_en_i && (set_vec[gc] || clr_vec[gc])) |=> $stable(output_latch_o[gc]))
            else $error("a latch bit changed with no strobe bit for it");

        a_bit_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
            general_out_pin_o[gc] != output_latch_o[gc])
            else $error("a pin does not drive the inverse of its latch bit");

        a_bit_pin_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
            !rst_i && clk_en_i && set_vec[gc] |=> !general_out_pin_o[gc])
            else $error("a set strobe bit did not drive its pin low");

        a_bit_pin_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
            !rst_i && clk_en_i && clr_vec[gc] |=> general_out_pin_o[gc])
            else $error("a clear strobe bit did not drive its pin high");

        a_bit_reset: assert property (@(posedge core_clk_i)
            rst_i |=> output_latch_o[gc] == LATCH_RST[gc])
            else $error("a latch bit did not take its reset value");

        a_bit_frozen: assert property (@(posedge core_clk_i) disable iff (rst_i)
            s_frozen |=> $stable(output_latch_o[gc]))
            else $error("a latch bit changed while clock enable low");
    end
endmodule // opl_output_port_set_clear_latch

// ### verif/tb_top.sv
// testbench for the set/clear output latch: host writes and latch/pin checks
// assumes the design's one-cycle write port and synchronous active-high reset
`timescale 1ns/1ps
module tb_top;
    import opl_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       rst_i      = 1'b1;
    logic       clk_en_i   = 1'b1;
    logic       wr_en_i    = 1'b0;
    logic [3:0] wr_addr_i  = 4'h0;
    logic [7:0] wr_data_i  = 8'h00;
    logic [7:0] latch_o;
    logic [7:0] pin_o;
    int         bad_count  = 0;
    int         n_compared = 0;

    always #5 core_clk_i = ~core_clk_i;

    opl_output_port_set_clear_latch DUT (
        .core_clk_i        (core_clk_i),
        .rst_i             (rst_i),
        .clk_en_i          (clk_en_i),
        .wr_addr_i         (wr_addr_i),
        .wr_data_i         (wr_data_i),
        .wr_en_i           (wr_en_i),
        .output_latch_o    (latch_o),
        .general_out_pin_o (pin_o)
    );

    // strobe stays high so consecutive calls give back-to-back writes
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wr_addr_i <= a;
        wr_data_i <= d;
        wr_en_i   <= 1'b1;
        @(posedge core_clk_i);
    endtask

    task automatic chk(input logic [7:0] exp);
        wr_en_i <= 1'b0;
        #1;
        n_compared++;
        if (latch_o !== exp || pin_o !== ~exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t latch=%h pins=%h exp=%h", $time, latch_o, pin_o, exp);
        end
        @(posedge core_clk_i);
    endtask

    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        chk(8'h00);
        wr(OPL_SET_ADDR, 8'h05);
        wr(OPL_CLR_ADDR, 8'h01);
        chk(8'h04);
        wr(OPL_SET_ADDR, 8'h30);
        wr(OPL_SET_ADDR, 8'hC0);
        chk(8'hF4);
        wr(OPL_CLR_ADDR, 8'h80);
        wr(OPL_CLR_ADDR, 8'h04);
        wr(OPL_SET_ADDR, 8'h0C);
        wr(OPL_CLR_ADDR, 8'h08);
        chk(8'h74);
        // every other address must leave the latch alone
        for (int a = 0; a < 14; a++) wr(4'(a), 8'hFF);
        chk(8'h74);
        clk_en_i <= 1'b0;
        wr(OPL_SET_ADDR, 8'h03);
        wr(OPL_CLR_ADDR, 8'h74);
        clk_en_i <= 1'b1;
        chk(8'h74);
        wr(OPL_SET_ADDR, 8'hFF);
        chk(8'hFF);
        rst_i <= 1'b1;
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        chk(8'h00);
        print_verdict();
    end
endmodule // tb_top
